/* hdl/cia_sequencer.sv */
/*
 * Interrupt entry and return sequencer of an 8-bit processor core.
 * Assumes the core on mclk pulses instr_boundary between instructions,
 * stalls while core_hold is high, and applies pc_load / sp_load values.
 * Memory answers a read in the cycle in which mem_req.re stands, on mem_rdata.
 */
// Operation
// - Interrupt request input provided to external logic
// - Take request only at instruction boundary
// - Clear enable, then run acknowledge cycle
// - Inserted restart or call pushes return address
// - Inserted restart or call loads service address
// - Stay disabled until enable instruction executes
// - Return pops counter from SP+1, SP+2
// - Input plus conditional jump costs twenty cycles
// - Four pushes, four pops cost eighty-four
// - Enable plus return add fifteen cycles
// - No counter increment; status in second period
module cia_sequencer
    import cia_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        irq_req,
    input  wire logic        instr_boundary,
    input  wire logic        ei_exec,
    input  wire logic        di_exec,
    input  wire logic        ret_exec,
    input  wire logic        seq_start,
    input  wire cia_seq_t    seq_kind,
    input  wire logic [15:0] pc_cur,
    input  wire logic [15:0] sp_cur,
    input  wire logic [7:0]  data_in,
    input  wire logic [7:0]  mem_rdata,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic             irq_ack_status,
    output logic             irq_enabled,
    output logic             core_hold,
    output logic             pc_load,
    output logic [15:0]      pc_new,
    output logic             sp_load,
    output logic [15:0]      sp_new,
    output logic             inject_valid,
    output logic [7:0]       inject_opcode,
    output logic             seq_busy,
    output cia_mem_req_t     mem_req
);

    // ------------------------------------------------------------------
    // Request synchroniser: change counts once stages 2 and 3 agree
    // ------------------------------------------------------------------
    logic [SYNC_STAGES-1:0] irq_sync;
    logic                   irq_level;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync  <= '0;
            irq_level <= 1'b0;
        end else begin
            irq_sync <= {irq_sync[SYNC_STAGES-2:0], irq_req};
            if (irq_sync[1] == irq_sync[2]) begin
                irq_level <= irq_sync[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Decode and next-state logic
    // ------------------------------------------------------------------
    cia_state_t  state;
    cia_state_t  next_state;
    logic        ie;
    logic [7:0]  vec_lo;
    logic [15:0] ret_pc;
    logic [15:0] svc_addr;
    logic        cost_start;
    logic        cost_done;
    cia_seq_t    cost_kind;

    // Level only, never stored: a request dropped before the boundary is lost
    wire take_irq   = (state == CIA_RUN) && instr_boundary && ie && irq_level;
    wire take_ret   = (state == CIA_RUN) && ret_exec && !take_irq;
    wire take_seq   = (state == CIA_RUN) && seq_start && !take_irq && !ret_exec;
    wire is_rst     = (data_in & RST_MASK) == RST_MATCH;
    wire is_call    = (data_in == OP_CALL);
    wire [15:0] rst_addr = {10'h000, data_in[5:3], 3'b000};
    wire [15:0] sp_dec1  = sp_cur - 16'h0001;
    wire [15:0] sp_dec2  = sp_cur - 16'h0002;
    wire [15:0] sp_inc1  = sp_cur + 16'h0001;
    wire [15:0] sp_inc2  = sp_cur + 16'h0002;
    wire ei_ret_done = (state == CIA_COST) && cost_done && (cost_kind == CIA_SEQ_EI_RET);
    // Acceptance outranks an enable in the same cycle, and disable outranks enable
    wire next_ie     = (take_irq || di_exec)    ? 1'b0 :
                       (ei_exec || ei_ret_done) ? 1'b1 : ie;

    always_comb begin
        next_state = state;
        case (state)
            CIA_RUN: begin
                if (take_irq) begin
                    next_state = CIA_ACK_T1;
                end else if (take_ret) begin
                    next_state = CIA_RET_LO;
                end else if (take_seq) begin
                    next_state = CIA_COST;
                end
            end
            CIA_ACK_T1: next_state = CIA_ACK_T2;
            CIA_ACK_T2: next_state = CIA_ACK_T3;
            CIA_ACK_T3: begin
                if (is_call) begin
                    next_state = CIA_ACK_LO;
                end else if (is_rst) begin
                    next_state = CIA_PUSH_HI;
                end else begin
                    next_state = CIA_RUN;
                end
            end
            CIA_ACK_LO:   next_state = CIA_ACK_HI;
            CIA_ACK_HI:   next_state = CIA_PUSH_HI;
            CIA_PUSH_HI:  next_state = CIA_PUSH_LO;
            CIA_PUSH_LO:  next_state = CIA_VECTOR;
            CIA_VECTOR:   next_state = CIA_RUN;
            CIA_COST: begin
                if (ei_ret_done) begin
                    next_state = CIA_RET_LO;
                end else if (cost_done) begin
                    next_state = CIA_RUN;
                end
            end
            CIA_RET_LO:   next_state = CIA_RET_HI;
            CIA_RET_HI:   next_state = CIA_RET_LOAD;
            CIA_RET_LOAD: next_state = CIA_RUN;
            default:      next_state = CIA_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // Enable flag and captured bytes
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= CIA_RUN;
            ie       <= IE_RESET;
            vec_lo   <= 8'h00;
            ret_pc   <= ADDR_RESET;
            svc_addr <= ADDR_RESET;
        end else begin
            state <= next_state;
            ie <= next_ie;
            if (take_irq) begin
                ret_pc <= pc_cur;
            end
            if (state == CIA_ACK_T3) begin
                svc_addr <= rst_addr;
            end
            if (state == CIA_ACK_LO) begin
                vec_lo <= data_in;
            end
            if (state == CIA_ACK_HI) begin
                svc_addr <= {data_in, vec_lo};
            end
            if (state == CIA_RET_HI) begin
                ret_pc[7:0] <= mem_rdata;
            end
            if (state == CIA_RET_LOAD) begin
                ret_pc[15:8] <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Cycle-cost timer
    // ------------------------------------------------------------------
    assign cost_start = take_seq;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cost_kind <= CIA_SEQ_POLL;
        end else if (take_seq) begin
            cost_kind <= seq_kind;
        end
    end

    cia_cost_timer u_cost (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (cost_start),
        .kind  (seq_kind),
        .busy  (seq_busy),
        .done  (cost_done)
    );

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    wire          hold_next  = (next_state != CIA_RUN);
    wire          ack_t2     = (next_state == CIA_ACK_T2);
    wire          ack_fetch  = (next_state == CIA_ACK_T1) || (next_state == CIA_ACK_T2) ||
                               (next_state == CIA_ACK_T3) || (next_state == CIA_ACK_LO) ||
                               (next_state == CIA_ACK_HI);
    wire          inj_next   = (state == CIA_ACK_T3) && !is_call && !is_rst;
    wire          vec_next   = (state == CIA_VECTOR);
    wire          ret_ld     = (state == CIA_RET_LOAD);
    cia_mem_req_t next_mem;

    always_comb begin
        next_mem = '{addr: ADDR_RESET, wdata: 8'h00, we: 1'b0, re: 1'b0};
        case (state)
            CIA_PUSH_HI: next_mem = '{addr: sp_dec1, wdata: ret_pc[15:8],
                                      we: 1'b1, re: 1'b0};
            CIA_PUSH_LO: next_mem = '{addr: sp_dec2, wdata: ret_pc[7:0],
                                      we: 1'b1, re: 1'b0};
            CIA_RET_LO:  next_mem = '{addr: sp_inc1, wdata: 8'h00,
                                      we: 1'b0, re: 1'b1};
            CIA_RET_HI:  next_mem = '{addr: sp_inc2, wdata: 8'h00,
                                      we: 1'b0, re: 1'b1};
            default:     next_mem = '{addr: ADDR_RESET, wdata: 8'h00, we: 1'b0, re: 1'b0};
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out       <= 8'h00;
            data_oe        <= 1'b0;
            irq_ack_status <= 1'b0;
            irq_enabled    <= IE_RESET;
            core_hold      <= 1'b0;
            pc_load        <= 1'b0;
            pc_new         <= ADDR_RESET;
            sp_load        <= 1'b0;
            sp_new         <= ADDR_RESET;
            inject_valid   <= 1'b0;
            inject_opcode  <= 8'h00;
            mem_req        <= '{addr: ADDR_RESET, wdata: 8'h00, we: 1'b0, re: 1'b0};
        end else begin
            // Counter is never advanced here, so the core keeps pc_cur untouched until pc_load at vector or return
            core_hold      <= hold_next;
            data_oe        <= ack_t2;
            data_out       <= ack_t2 ? ACK_STATUS_BYTE : 8'h00;
            irq_ack_status <= ack_fetch;
            // Flag follows the enable in the same cycle as the hold rises
            irq_enabled    <= next_ie;
            inject_valid   <= inj_next;
            inject_opcode  <= inj_next ? data_in : 8'h00;
            pc_load        <= vec_next || ret_ld;
            pc_new         <= vec_next ? svc_addr :
                              ret_ld   ? {mem_rdata, ret_pc[7:0]} : pc_new;
            sp_load        <= vec_next || ret_ld;
            sp_new         <= vec_next ? sp_dec2 :
                              ret_ld ? sp_inc2 : sp_new;
            mem_req        <= next_mem;
        end
    end

endmodule : cia_sequencer

/* include/cia_pkg.sv */
/*
 * Shared constants and types for the interrupt entry and return sequencer.
 * Assumes one clock (mclk, 200 MHz) and a core on that clock that reports
 * instruction boundaries and executes everything outside this block.
 */
package cia_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          SYNC_STAGES     = 3;

    // ------------------------------------------------------------------
    // Cycle costs of the polling and context sequences (mclk cycles)
    // ------------------------------------------------------------------
    localparam logic [6:0]  POLL_CYCLES     = 7'd20;
    localparam logic [6:0]  SAVE_CYCLES     = 7'd84;
    localparam logic [6:0]  EI_RET_CYCLES   = 7'd15;

    // ------------------------------------------------------------------
    // Opcodes and status
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_CALL         = 8'hcd;
    localparam logic [7:0]  RST_MASK        = 8'hc7;
    localparam logic [7:0]  RST_MATCH       = 8'hc7;
    localparam logic [7:0]  OP_XCHG_TOP     = 8'he3;
    localparam logic [7:0]  ACK_STATUS_BYTE = 8'h23;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        IE_RESET        = 1'b0;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;

    typedef enum logic [1:0] {
        CIA_SEQ_POLL,
        CIA_SEQ_SAVE,
        CIA_SEQ_EI_RET
    } cia_seq_t;

    typedef enum {
        CIA_RUN,
        CIA_ACK_T1,
        CIA_ACK_T2,
        CIA_ACK_T3,
        CIA_ACK_LO,
        CIA_ACK_HI,
        CIA_PUSH_HI,
        CIA_PUSH_LO,
        CIA_VECTOR,
        CIA_COST,
        CIA_RET_LO,
        CIA_RET_HI,
        CIA_RET_LOAD
    } cia_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } cia_mem_req_t;

endpackage : cia_pkg

/* hdl/cia_cost_timer.sv */
/*
 * Cycle-cost timer: busy for the documented number of cycles of a
 * polling, context-save or enable-and-return sequence, then one done pulse.
 * Assumes start is a one-cycle pulse from logic on mclk, ignored while busy.
 */
module cia_cost_timer
    import cia_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire logic     start,
    input  wire cia_seq_t kind,
    output logic          busy,
    output logic          done
);

    logic [6:0] remain;
    logic [6:0] next_remain;
    wire  [6:0] load_val;

    assign load_val = (kind == CIA_SEQ_POLL) ? POLL_CYCLES :
                      (kind == CIA_SEQ_SAVE) ? SAVE_CYCLES :
                                               EI_RET_CYCLES;

    assign next_remain = (start && !busy) ? load_val :
                         (remain != 7'h00) ? remain - 7'h01 : 7'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= 7'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            remain <= next_remain;
            busy   <= (next_remain != 7'h00);
            done   <= (remain == 7'h01);
        end
    end

endmodule : cia_cost_timer

/* dv/cia_sequencer_props.sv */
/*
 * Concurrent checks on the ports of the interrupt entry and return sequencer.
 * Assumes it is bound into cia_sequencer and sees only its ports.
 */
module cia_sequencer_props
    import cia_pkg::*;
(
    input wire logic         mclk,
    input wire logic         rst_n,
    input wire logic         instr_boundary,
    input wire logic         ei_exec,
    input wire logic         di_exec,
    input wire logic         seq_start,
    input wire cia_seq_t     seq_kind,
    input wire logic [15:0]  sp_cur,
    input wire logic [7:0]   data_out,
    input wire logic         data_oe,
    input wire logic         irq_ack_status,
    input wire logic         irq_enabled,
    input wire logic         core_hold,
    input wire logic         pc_load,
    input wire logic         sp_load,
    input wire logic [15:0]  sp_new,
    input wire logic         seq_busy,
    input wire cia_mem_req_t mem_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Busy length of a costed sequence
    // ------------------------------------------------------------------
    logic [6:0] busy_cnt;
    cia_seq_t   kind_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 7'h00;
            kind_q   <= CIA_SEQ_POLL;
        end else begin
            busy_cnt <= seq_busy ? busy_cnt + 7'h01 : 7'h00;
            if (seq_start && !seq_busy)
                kind_q <= seq_kind;
        end
    end
    wire logic [6:0] busy_exp = (kind_q == CIA_SEQ_POLL) ? 7'h14 :
                                (kind_q == CIA_SEQ_SAVE) ? 7'h54 : 7'h0f;

    sequence s_ack_rst;
        irq_ack_status [*3] ##1 !irq_ack_status;
    endsequence
    sequence s_ack_call;
        irq_ack_status [*5] ##1 !irq_ack_status;
    endsequence

    chk_take_boundary: assert property ($rose(irq_ack_status) |->
        $past(instr_boundary) && $past(irq_enabled) && !irq_enabled && core_hold)
        else $error("acknowledge started without an enabled boundary");
    chk_status_second: assert property ($rose(irq_ack_status) |=>
        data_oe && data_out == ACK_STATUS_BYTE ##1 !data_oe)
        else $error("acknowledge status not in second period");
    chk_ack_length: assert property ($rose(irq_ack_status) |->
        s_ack_rst or s_ack_call)
        else $error("acknowledge fetch has wrong length");
    chk_no_pc_step: assert property (irq_ack_status |-> core_hold && !pc_load)
        else $error("counter loaded during acknowledge");
    chk_ie_drop: assert property ($fell(irq_enabled) |->
        $past(di_exec) || $rose(irq_ack_status))
        else $error("enable dropped without cause");
    chk_ie_rise: assert property ($rose(irq_enabled) |->
        $past(ei_exec) || $past(seq_busy) || $past(seq_busy, 2))
        else $error("enable set without enable instruction");
    chk_push_order: assert property ($rose(mem_req.we) |->
        mem_req.addr == sp_cur - 16'h0001 ##1 mem_req.we && mem_req.addr == sp_cur - 16'h0002
        ##1 pc_load && sp_load && sp_new == sp_cur - 16'h0002)
        else $error("push order or vector load wrong");
    chk_pop_order: assert property ($rose(mem_req.re) |->
        mem_req.addr == sp_cur + 16'h0001 ##1 mem_req.re && mem_req.addr == sp_cur + 16'h0002
        ##1 pc_load && sp_load && sp_new == sp_cur + 16'h0002)
        else $error("return pop order wrong");
    chk_cost_len: assert property ($fell(seq_busy) |-> busy_cnt == busy_exp)
        else $error("costed sequence has wrong length");
endmodule : cia_sequencer_props

/* dv/cia_irq_src.sv */
/*
 * External interrupt request and vector logic.
 * Assumes the bench sets raise and the instruction bytes between requests.
 */
module cia_irq_src (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       raise,
    input  wire logic [7:0] op,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    input  wire logic       irq_ack_status,
    output logic            irq_req,
    output logic [7:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 0;
    initial irq_req = 1'b0;
    initial data_in = 8'h5a;
    // Outside the inserted bytes the bus toggles, so stale data never matches
    always @(negedge mclk) begin
        irq_req <= raise && rst_n;
        idx     <= irq_ack_status ? idx + 1 : 0;
        case (irq_ack_status ? idx : -1)
            2: data_in <= op;
            3: data_in <= lo;
            4: data_in <= hi;
            default: data_in <= ~data_in;
        endcase
    end
endmodule : cia_irq_src

/* dv/tb.sv */
/*
 * Self-checking bench for the interrupt sequencer, with a byte memory model.
 * Assumes the design and checker files are compiled before it.
 */
module tb
    import cia_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] BND = 5'h10, EI = 5'h08, DI = 5'h04, RET = 5'h02, GO = 5'h01;
    logic         mclk, rst_n, raise, instr_boundary, ei_exec, di_exec, ret_exec, seq_start;
    logic         irq_req, data_oe, irq_ack_status, irq_enabled, core_hold, pc_load;
    logic         sp_load, inject_valid, seq_busy;
    cia_seq_t     seq_kind;
    logic [15:0]  pc_cur, sp_cur, pc_new, sp_new;
    logic [7:0]   data_in, mem_rdata, data_out, inject_opcode, op, lo, hi;
    cia_mem_req_t mem_req;
    logic [7:0]   mem [0:65535];
    int           error_cnt = 0, checks = 0, cyc = 0;

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (mem_req.we === 1'b1)
            mem[mem_req.addr] <= mem_req.wdata;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    // Reads answer while the request stands; idle reads show a junk byte
    assign mem_rdata = (mem_req.re === 1'b1) ? mem[mem_req.addr] : 8'ha5;

    cia_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .irq_req(irq_req),
        .instr_boundary(instr_boundary), .ei_exec(ei_exec), .di_exec(di_exec),
        .ret_exec(ret_exec), .seq_start(seq_start), .seq_kind(seq_kind), .pc_cur(pc_cur),
        .sp_cur(sp_cur), .data_in(data_in), .mem_rdata(mem_rdata), .data_out(data_out),
        .data_oe(data_oe), .irq_ack_status(irq_ack_status), .irq_enabled(irq_enabled),
        .core_hold(core_hold), .pc_load(pc_load), .pc_new(pc_new), .sp_load(sp_load),
        .sp_new(sp_new), .inject_valid(inject_valid), .inject_opcode(inject_opcode),
        .seq_busy(seq_busy), .mem_req(mem_req));
    cia_irq_src src_u (.mclk(mclk), .rst_n(rst_n), .raise(raise), .op(op), .lo(lo), .hi(hi),
        .irq_ack_status(irq_ack_status), .irq_req(irq_req), .data_in(data_in));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    task automatic core(input logic [4:0] v);
        @(negedge mclk);
        {instr_boundary, ei_exec, di_exec, ret_exec, seq_start} = v;
        @(negedge mclk);
        {instr_boundary, ei_exec, di_exec, ret_exec, seq_start} = 5'h00;
    endtask : core
    task automatic wait_pc();
        for (int i = 0; i < 40 && pc_load !== 1'b1; i++)
            @(negedge mclk);
    endtask : wait_pc
    // Long enough to cover the request synchroniser before the boundary is driven
    task automatic take(input logic [4:0] v);
        raise = 1'b1;
        repeat (6) @(negedge mclk);
        core(v);
    endtask : take
    task automatic nohold(input string name);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(negedge mclk);
            seen |= (core_hold === 1'b1);
        end
        cmp(name, 16'h0000, 16'(seen));
    endtask : nohold

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_rst();
        for (int n = 0; n < 8; n++) begin
            pc_cur = 16'h1200 + 16'(n);
            sp_cur = 16'h8000;
            op     = 8'hc7 | 8'(n << 3);
            core(EI);
            take(BND);
            wait_pc();
            cmp("rst pc", 16'(n * 8), pc_new);
            cmp("rst sp", 16'h7ffe, sp_new);
            cmp("rst stack", pc_cur, {mem[16'h7fff], mem[16'h7ffe]});
            cmp("rst ie", 16'h0000, 16'(irq_enabled));
            core(BND);
            nohold("held off");
            raise = 1'b0;
        end
    endtask : t_rst
    task automatic t_call_ret();
        {op, lo, hi} = 24'hcd3412;
        pc_cur = 16'h4321;
        sp_cur = 16'h9000;
        core(EI);
        take(BND);
        wait_pc();
        raise = 1'b0;
        cmp("call pc", 16'h1234, pc_new);
        cmp("call stack", 16'h4321, {mem[16'h8fff], mem[16'h8ffe]});
        repeat (2) @(negedge mclk);
        // Return pops SP+1 (low) and SP+2 (high): the pair sits at 8ffe and 8fff
        sp_cur = 16'h8ffd;
        core(RET);
        wait_pc();
        cmp("ret pc", 16'h4321, pc_new);
        cmp("ret sp", 16'h8fff, sp_new);
    endtask : t_call_ret
    task automatic t_gate();
        logic seen;
        op = 8'h00;
        take(BND);
        nohold("disabled");
        raise = 1'b0;
        repeat (6) @(negedge mclk);
        core(EI);
        core(BND);
        nohold("not latched");
        raise = 1'b1;
        nohold("no boundary");
        core(DI);
        core(BND);
        nohold("after di");
        core(EI);
        core(BND);
        seen = 1'b0;
        repeat (20) begin
            @(negedge mclk);
            seen |= (inject_valid === 1'b1 && inject_opcode === 8'h00);
        end
        raise = 1'b0;
        cmp("inject", 16'h0001, 16'(seen));
    endtask : t_gate
    task automatic t_cost();
        int n;
        sp_cur = 16'h8ffd;
        for (int k = 0; k < 3; k++) begin
            seq_kind = cia_seq_t'(k);
            core(GO);
            n = 0;
            while (seq_busy === 1'b1 && n < 200) begin
                n++;
                @(negedge mclk);
            end
            cmp("busy", 16'(k == 0 ? 20 : k == 1 ? 84 : 15), 16'(n));
        end
        wait_pc();
        cmp("ei ret pc", 16'h4321, pc_new);
        cmp("ei ret ie", 16'h0001, 16'(irq_enabled));
    endtask : t_cost

    task automatic final_report();
        $display("error_cnt %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    initial begin
        {mclk, rst_n, raise, instr_boundary, ei_exec, di_exec, ret_exec, seq_start} = 8'h00;
        {pc_cur, sp_cur, op, lo, hi} = 56'h0;
        seq_kind = CIA_SEQ_POLL;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_rst();
        t_call_ret();
        t_gate();
        t_cost();
        final_report();
    end
endmodule : tb

bind cia_sequencer cia_sequencer_props chk_u (.mclk(mclk), .rst_n(rst_n),
    .instr_boundary(instr_boundary), .ei_exec(ei_exec), .di_exec(di_exec),
    .seq_start(seq_start), .seq_kind(seq_kind), .sp_cur(sp_cur), .data_out(data_out),
    .data_oe(data_oe), .irq_ack_status(irq_ack_status), .irq_enabled(irq_enabled),
    .core_hold(core_hold), .pc_load(pc_load), .sp_load(sp_load), .sp_new(sp_new),
    .seq_busy(seq_busy), .mem_req(mem_req));
